// ===== common/bst_cfg.svh
// Summary of operation
// - Exactly one register between serial in/out
// - Sample on rise, change output on fall
// - Instruction register is three bits wide
// - Reset loads identification-read instruction
// - Capture-IR loads 01 into low bits
// - One-bit bypass, cleared on capture
// - Boundary register captures pins, then shifts
// - Serial in at MSB, out at LSB
// - Identification read captures hardwired 32-bit value
// - New instruction takes effect at Update-IR
// - Controller loads any code it is given; avoiding reserved codes is the user's duty
// - EXTEST drives preloaded cells onto outputs
// - Capture-with-float floats all memory outputs
// - SAMPLE/PRELOAD snapshots pins without disturbing memory
// - Preload latches shifted pattern, concurrent shifting
// - BYPASS routes through single bypass cell
// - Last cell controls output bus under EXTEST
// - Output control cell preset high at reset
// - Controller programs control cell via preload/EXTEST
// - Five high mode-select edges reset logic
// - Fixed instruction encodings, three codes reserved
// - Identification value bit zero is one
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
`define BST_IR_W       3
`define BST_ID_W       32
`define BST_IR_CAPTURE 2'h1
`define BST_OP_EXTEST  3'h0
`define BST_OP_IDCODE  3'h1
`define BST_OP_SAMPZ   3'h2
`define BST_OP_SAMPLE  3'h4
`define BST_OP_BYPASS  3'h7
`define BST_ID_VALUE   32'h0000_0001
`define BST_TLR_EDGES  3'h5
`define BST_CLK_DIV    4'h4
`endif

// ===== common/bst_pkg.sv
package bst_pkg;
   typedef enum logic [3:0] {
      ST_TLR = 4'hf, ST_RTI = 4'hc, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
      ST_SH_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PA_DR = 4'h3, ST_EX2_DR = 4'h0,
      ST_UP_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'he, ST_SH_IR = 4'ha,
      ST_EX1_IR = 4'h9, ST_PA_IR = 4'hb, ST_EX2_IR = 4'h8, ST_UP_IR = 4'hd
   } bst_state_t;
endpackage : bst_pkg

// ===== common/bst_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bst_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo_o;
   logic tdo_oe;
   modport dev (input tck, input tms, input tdi, output tdo_o, output tdo_oe);
   modport ctl (output tck, output tms, output tdi, input tdo_o, input tdo_oe);
endinterface : bst_if
`default_nettype wire

// ===== rtl/bst_tap.sv
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"
module bst_tap
   import bst_pkg::*;
#(
   parameter int CELLS   = 85,
   parameter int PIN_W   = 84,
   parameter logic [31:0] ID_VALUE = `BST_ID_VALUE  // Arbitrary code, bit 0 forced
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Link
   bst_if.dev                    lnk,
   // Pin ring
   input  wire logic [PIN_W-1:0] pin_in,
   output logic      [PIN_W-1:0] pin_drive,
   output logic                  extest_active,
   output logic                  out_enable,
   output logic                  out_float
);
   typedef struct packed {
      logic [1:0]            tck_s, tms_s, tdi_s;
      logic                  tck_p;
      bst_state_t            st;
      logic [`BST_IR_W-1:0]  ir_sh, ir;
      logic                  byp;
      logic [`BST_ID_W-1:0]  id_sh;
      logic [CELLS-1:0]      bsr_sh, bsr_up;
      logic                  tdo, tdo_oe;
      logic [2:0]            hi_cnt;
      logic [PIN_W-1:0]      pin_s1, pin_s2;
      logic [PIN_W-1:0]      drv;
      logic                  ext, oen, flt;
   } bst_regs_t;
   bst_regs_t q, d;
   logic rise, fall, tms, tdi, sel_bsr;

   function automatic bst_state_t nxt(input bst_state_t s, input logic m);
      case (s)
         ST_TLR:    nxt = m ? ST_TLR    : ST_RTI;
         ST_RTI:    nxt = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: nxt = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  nxt = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt = m ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  nxt = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: nxt = m ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  nxt = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: nxt = m ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: nxt = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  nxt = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt = m ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  nxt = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: nxt = m ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  nxt = m ? ST_SEL_DR : ST_RTI;
         default:   nxt = ST_TLR;
      endcase
   endfunction : nxt

   always_comb begin
      d = q;
      d.tck_s = {q.tck_s[0], lnk.tck};
      d.tms_s = {q.tms_s[0], lnk.tms};
      d.tdi_s = {q.tdi_s[0], lnk.tdi};
      d.tck_p = q.tck_s[1];
      // Pins are asynchronous to mclk, two stages before capture
      d.pin_s1 = pin_in;
      d.pin_s2 = q.pin_s1;
      rise = q.tck_s[1] & ~q.tck_p;
      fall = ~q.tck_s[1] & q.tck_p;
      tms = q.tms_s[1];
      tdi = q.tdi_s[1];
      sel_bsr = (q.ir == `BST_OP_EXTEST) || (q.ir == `BST_OP_SAMPZ)
                || (q.ir == `BST_OP_SAMPLE);
      if (rise) begin
         d.st = nxt(q.st, tms);
         // Watchdog so a lost state still resets after five highs
         d.hi_cnt = tms ? ((q.hi_cnt == `BST_TLR_EDGES) ? q.hi_cnt : q.hi_cnt + 3'h1) : 3'h0;
         if (tms && q.hi_cnt == `BST_TLR_EDGES - 3'h1)
            d.st = ST_TLR;
         case (q.st)
            ST_CAP_IR: d.ir_sh = {q.ir_sh[`BST_IR_W-1:2], `BST_IR_CAPTURE};
            ST_SH_IR:  d.ir_sh = {tdi, q.ir_sh[`BST_IR_W-1:1]};
            ST_UP_IR:  d.ir = q.ir_sh;
            ST_CAP_DR: begin
               d.byp = 1'b0;
               d.id_sh = ID_VALUE | 32'h1;
               d.bsr_sh = {q.bsr_up[CELLS-1], {(CELLS-PIN_W-1){1'b0}}, q.pin_s2};
            end
            ST_SH_DR: begin
               d.byp = tdi;
               d.id_sh = {tdi, q.id_sh[`BST_ID_W-1:1]};
               d.bsr_sh = {tdi, q.bsr_sh[CELLS-1:1]};
            end
            ST_UP_DR:  if (sel_bsr) d.bsr_up = q.bsr_sh;
            default: ;
         endcase
         if (d.st == ST_TLR) begin
            d.ir = `BST_OP_IDCODE;
            d.bsr_up[CELLS-1] = 1'b1;
         end
      end
      if (fall) begin
         d.tdo_oe = (q.st == ST_SH_IR) || (q.st == ST_SH_DR);
         if (q.st == ST_SH_IR)
            d.tdo = q.ir_sh[0];
         else case (q.ir)
            `BST_OP_IDCODE: d.tdo = q.id_sh[0];
            `BST_OP_BYPASS: d.tdo = q.byp;
            default:        d.tdo = q.bsr_sh[0];
         endcase
      end
      d.ext = (q.ir == `BST_OP_EXTEST);
      d.drv = q.bsr_up[PIN_W-1:0];
      d.oen = ~d.ext | q.bsr_up[CELLS-1];
      d.flt = (q.ir == `BST_OP_SAMPZ) || (d.ext & ~q.bsr_up[CELLS-1]);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         q.st <= ST_TLR;
         q.ir <= `BST_OP_IDCODE;
         q.bsr_up[CELLS-1] <= 1'b1;
         q.oen <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign lnk.tdo_o = q.tdo;
   assign lnk.tdo_oe = q.tdo_oe;
   assign pin_drive = q.drv;
   assign extest_active = q.ext;
   assign out_enable = q.oen;
   assign out_float = q.flt;
endmodule : bst_tap
`default_nettype wire

// ===== rtl/bst_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"
module bst_ctl
   import bst_pkg::*;
#(
   parameter int LEN_W = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Link
   bst_if.ctl                    lnk,
   // User command: shift len+1 bits on IR (is_ir) or DR path
   input  wire logic             start,
   input  wire logic             is_ir,
   input  wire logic [LEN_W-1:0] len,
   input  wire logic [127:0]     wdata,
   output logic                  busy,
   output logic                  done,
   output logic [127:0]          rdata
);
   typedef enum logic [2:0] {
      C_RST = 3'h0, C_IDLE = 3'h1, C_SCAN = 3'h3, C_DONE = 3'h2
   } bst_cst_t;
   typedef struct packed {
      bst_cst_t          cs;
      logic [3:0]        div;
      logic              tck, tms, tdi;
      logic [1:0]        tdo_s;
      logic [7:0]        step;
      logic [LEN_W-1:0]  cnt, len;
      logic              ir;
      logic [127:0]      sh;
      logic              busy, done;
   } bst_cregs_t;
   bst_cregs_t q, d;
   logic tick_fall, tick_rise;
   // Fixed path prefix before shift: RTI->SelDR(->SelIR)->Cap->Shift
   logic [3:0] pre;

   always_comb begin
      d = q;
      d.tdo_s = {q.tdo_s[0], lnk.tdo_o};
      d.done = 1'b0;
      d.div = (q.div == `BST_CLK_DIV - 4'h1) ? 4'h0 : q.div + 4'h1;
      tick_fall = (q.div == `BST_CLK_DIV - 4'h1) && q.tck;
      tick_rise = (q.div == `BST_CLK_DIV - 4'h1) && !q.tck;
      pre = q.ir ? 4'hc : 4'h8; // bits: 1,1,0,0 or 1,0,0
      if (tick_rise) d.tck = 1'b1;
      if (tick_fall) begin
         d.tck = 1'b0;
         // Change TMS/TDI on falling edge so device samples on rise
         case (q.cs)
            C_RST: begin
               d.tms = 1'b1;
               d.step = q.step + 8'h1;
               if (q.step == {5'h0, `BST_TLR_EDGES}) begin
                  d.tms = 1'b0;
                  d.cs = C_IDLE;
               end
            end
            C_IDLE: begin
               d.tms = 1'b0;
               if (q.busy) begin
                  d.cs = C_SCAN;
                  d.step = 8'h0;
               end
            end
            C_SCAN: begin
               d.step = q.step + 8'h1;
               if (q.step < (q.ir ? 8'h4 : 8'h3)) begin
                  d.tms = pre[3 - q.step[1:0]];
                  d.tdi = q.sh[0];
               end else begin
                  if (q.step != (q.ir ? 8'h4 : 8'h3))
                     d.sh = {q.tdo_s[1], q.sh[127:1]};
                  d.tdi = d.sh[0];
                  d.tms = (q.cnt == LEN_W'(1)); // Exit1 on last bit
                  d.cnt = q.cnt - LEN_W'(1);
                  if (q.cnt == '0) begin
                     d.tms = 1'b1; // Exit1 -> Update
                     d.cs = C_DONE;
                  end
               end
            end
            C_DONE: begin
               d.tms = 1'b0; // Update -> RTI
               d.busy = 1'b0;
               d.done = 1'b1;
               d.cs = C_IDLE;
            end
            default: d.cs = C_RST;
         endcase
      end
      if (start && !q.busy) begin // are the user's duty
         d.busy = 1'b1;
         d.ir = is_ir;
         d.len = len;
         // One extra count so the last of len+1 bits is shifted before Exit1
         d.cnt = len + LEN_W'(1);
         d.sh = wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         q.cs <= C_RST;
         q.tms <= 1'b1;
         q.tdi <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign lnk.tck = q.tck;
   assign lnk.tms = q.tms;
   assign lnk.tdi = q.tdi;
   assign busy = q.busy;
   assign done = q.done;
   assign rdata = q.sh;
endmodule : bst_ctl
`default_nettype wire

// ===== test/bst_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"
module bst_link_assertions
   import bst_pkg::*;
#(
   parameter logic [31:0] ID_VALUE = `BST_ID_VALUE
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe
);
   typedef struct packed {
      logic       tck;
      bst_state_t st;
      logic [2:0] ir_sh;
      logic [2:0] ir;
   } bst_mon_t;
   bst_mon_t m_q;
   bst_mon_t m_d;
   logic     rise;
   // Reference controller, trails the wire by one mclk
   assign rise = tck & ~m_q.tck;
   always_comb begin
      m_d = m_q;
      m_d.tck = tck;
      if (m_q.st == ST_UP_IR) m_d.ir = m_q.ir_sh;
      if (m_q.st == ST_TLR) m_d.ir = `BST_OP_IDCODE;
      if (rise) begin
         if (m_q.st == ST_SH_IR) m_d.ir_sh = {tdi, m_q.ir_sh[2:1]};
         case (m_q.st)
            ST_TLR:                     m_d.st = tms ? ST_TLR : ST_RTI;
            ST_RTI, ST_UP_DR, ST_UP_IR: m_d.st = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR:                  m_d.st = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR, ST_SH_DR:        m_d.st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR:                  m_d.st = tms ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR:                   m_d.st = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR:                  m_d.st = tms ? ST_UP_DR : ST_SH_DR;
            ST_SEL_IR:                  m_d.st = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR, ST_SH_IR:        m_d.st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR:                  m_d.st = tms ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR:                   m_d.st = tms ? ST_EX2_IR : ST_PA_IR;
            default:                    m_d.st = tms ? ST_UP_IR : ST_SH_IR;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) m_q <= '{1'b0, ST_TLR, 3'h0, `BST_OP_IDCODE};
      else m_q <= m_d;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_enter(bst_state_t s);
      $rose(tdo_oe) && m_q.st == s;
   endsequence
   // Period is exactly 8 mclk, so bit two sits 8 cycles after bit one
   sequence s_bits(logic b0, logic b1);
      ##1 tdo_o == b0 ##8 tdo_o == b1;
   endsequence
   property p_tdo_fall; $changed(tdo_o) && tdo_oe |-> !$past(tck, 3); endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved after a rise");
   property p_ctl_fall; $changed({tms, tdi}) |-> !tck; endproperty
   a_ctl_fall: assert property (p_ctl_fall) else $error("tms or tdi moved while tck high");
   property p_oe_rise; $rose(tdo_oe) |-> m_q.st inside {ST_SH_DR, ST_SH_IR}; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("tdo enabled outside shift");
   property p_oe_fall; $fell(tdo_oe) |-> m_q.st inside {ST_EX1_DR, ST_EX1_IR}; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("tdo released at wrong state");
   property p_oe_hold; $rose(tdo_oe) |-> tdo_oe [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("tdo enable dropped mid bit");
   property p_ir_cap; s_enter(ST_SH_IR) |-> s_bits(1'b1, 1'b0); endproperty
   a_ir_cap: assert property (p_ir_cap) else $error("instruction capture not 01");
   property p_id_low; s_enter(ST_SH_DR) ##0 m_q.ir == `BST_OP_IDCODE |-> s_bits(ID_VALUE[0], ID_VALUE[1]); endproperty
   a_id_low: assert property (p_id_low) else $error("identification bits wrong");
   property p_byp_zero; s_enter(ST_SH_DR) ##0 m_q.ir == `BST_OP_BYPASS |-> ##1 !tdo_o; endproperty
   a_byp_zero: assert property (p_byp_zero) else $error("bypass cell not cleared");
   property p_byp_pass; rise && m_q.st == ST_SH_DR && !tms && m_q.ir == `BST_OP_BYPASS |-> ##10 tdo_o == $past(tdi, 10); endproperty
   a_byp_pass: assert property (p_byp_pass) else $error("bypass path not one cell");
endmodule : bst_link_assertions
`default_nettype wire

// ===== test/sram_boundary_scan_tap_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"
module sram_boundary_scan_tap_regs_test;
   localparam logic [31:0] ID_VALUE = 32'h1234_5679;  // Arbitrary code, bit 0 set
   logic          mclk, rst, start, is_ir, busy, done, ext, oen, flt;
   logic [7:0]    len;
   logic [127:0]  wdata, rdata, got;
   logic [83:0]   pin_in, pin_drive;
   int            num_errors, tests_run, cycles;
   bst_if lnk ();
   bst_ctl u_bst_ctl (.mclk(mclk), .rst(rst), .lnk(lnk.ctl), .start(start), .is_ir(is_ir), .len(len),
                      .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
   bst_tap #(.CELLS(85), .PIN_W(84), .ID_VALUE(ID_VALUE)) u_bst_tap (.mclk(mclk), .rst(rst), .lnk(lnk.dev),
      .pin_in(pin_in), .pin_drive(pin_drive), .extest_active(ext), .out_enable(oen), .out_float(flt));
   bst_link_assertions #(.ID_VALUE(ID_VALUE)) u_bst_link_assertions (.mclk(mclk), .rst(rst), .tck(lnk.tck),
      .tms(lnk.tms), .tdi(lnk.tdi), .tdo_o(lnk.tdo_o), .tdo_oe(lnk.tdo_oe));
   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] seen);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic scan(input logic ir, input int n, input logic [127:0] w);
      int i;
      @(posedge mclk);
      start <= 1'b1;
      is_ir <= ir;
      len <= 8'(n - 1);
      wdata <= w;
      @(posedge mclk);
      start <= 1'b0;
      for (i = 0; i < 3000 && done !== 1'b1; i++) @(posedge mclk);
      if (i == 3000) check("done", 1'b1, 1'b0);
      // Captured bits enter at the top of rdata
      got = rdata >> (128 - n);
      repeat (8) @(posedge mclk);
   endtask : scan
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      rst = 1'b1; start = 1'b0; is_ir = 1'b0; len = 8'h0; wdata = '0; pin_in = '0;
      num_errors = 0; tests_run = 0; cycles = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      scan(1'b0, 32, 128'h0);
      check("idcode", ID_VALUE, got);
      check("busy", 1'b0, busy);
      scan(1'b1, 3, `BST_OP_EXTEST);
      check("ir capture", 2'b01, got[1:0]);
      check("extest flag", 1'b1, ext);
      check("preset enable", 1'b1, oen);
      pin_in <= {21{4'h3}};
      scan(1'b0, 85, {1'b0, {21{4'hc}}});
      check("extest capture", {21{4'h3}}, got[83:0]);
      check("extest drive", {21{4'hc}}, pin_drive);
      check("bus float", 2'b01, {oen, flt});
      scan(1'b1, 3, `BST_OP_SAMPLE);
      check("sample flags", 3'b010, {ext, oen, flt});
      pin_in <= {21{4'h9}};
      scan(1'b0, 85, {1'b1, {21{4'h6}}});
      check("sample capture", {21{4'h9}}, got[83:0]);
      check("preload", {21{4'h6}}, pin_drive);
      scan(1'b1, 3, `BST_OP_EXTEST);
      check("bus enable", 3'b110, {ext, oen, flt});
      scan(1'b1, 3, `BST_OP_SAMPZ);
      check("float flags", 2'b01, {ext, flt});
      scan(1'b1, 3, `BST_OP_BYPASS);
      scan(1'b0, 8, 8'ha5);
      check("bypass", 8'h4a, got[7:0]);
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      scan(1'b0, 32, 128'h0);
      check("idcode again", ID_VALUE, got);
      final_report();
   end
endmodule : sram_boundary_scan_tap_regs_test
`default_nettype wire
